//--- bench/cmsf_engine_model.sv
// Behavioural protocol engine on the far side: pulses mailbox events into the block
`timescale 1ns/1ns
module cmsf_engine_model (
    input wire logic core_clk,
    output cmsf_pkg::cmsf_evt_t tx_ok_evt,
    output cmsf_pkg::cmsf_evt_t tx_abort_evt,
    output cmsf_pkg::cmsf_evt_t tx_active,
    output cmsf_pkg::cmsf_evt_t rx_store_evt
);
    // Idle on the wire unless set_busy marks a mailbox as being sent
    initial begin
        tx_ok_evt = '0;
        tx_abort_evt = '0;
        tx_active = '0;
        rx_store_evt = '0;
    end
    // One-cycle pulse, held for exactly one edge
    task automatic send_ok(input logic [cmsf_pkg::MB_W-1:0] mb);
        @(posedge core_clk);
        tx_ok_evt <= '{valid: 1'b1, mb: mb};
        @(posedge core_clk);
        tx_ok_evt.valid <= 1'b0;
    endtask
    task automatic store_rx(input logic [cmsf_pkg::MB_W-1:0] mb);
        @(posedge core_clk);
        rx_store_evt <= '{valid: 1'b1, mb: mb};
        @(posedge core_clk);
        rx_store_evt.valid <= 1'b0;
    endtask
    // A cancelled frame already on the wire ends in an abort pulse
    task automatic abort_tx(input logic [cmsf_pkg::MB_W-1:0] mb);
        @(posedge core_clk);
        tx_abort_evt <= '{valid: 1'b1, mb: mb};
        @(posedge core_clk);
        tx_abort_evt.valid <= 1'b0;
    endtask
    task automatic set_busy(input logic on, input logic [cmsf_pkg::MB_W-1:0] mb);
        @(posedge core_clk);
        tx_active <= '{valid: on, mb: mb};
    endtask
endmodule

//--- bench/test_can_mailbox_status_and_filter.sv
// Self-checking bench: register traffic over AXI4-Lite plus engine events
`timescale 1ns/1ns
module test_can_mailbox_status_and_filter;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b0, rready = 1'b0;
    logic [3:0] wstrb = 4'hF;
    logic [31:0] wdata = 32'h00000000, rdata, rv;
    logic awready, wready, bvalid, arready, rvalid, m31, txi, rxi, gi;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] trs, trr;
    cmsf_pkg::cmsf_evt_t ok_e, ab_e, act_e, rx_e;
    cmsf_pkg::cmsf_frame_t frame = '0, setup = '0;
    int n_fail = 0, compares = 0;
    always #2 core_clk = ~core_clk;
    cmsf_engine_model eng (.core_clk(core_clk), .tx_ok_evt(ok_e), .tx_abort_evt(ab_e),
        .tx_active(act_e), .rx_store_evt(rx_e));
    // Protection fields are ignored by the slave, so only they stay tied
    cmsf_top dut (.core_clk(core_clk), .rstn(rstn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .tx_ok_evt(ok_e), .tx_abort_evt(ab_e), .tx_active(act_e), .rx_store_evt(rx_e),
        .rx_frame(frame), .mb31_setup(setup), .transmit_request_bits(trs),
        .transmit_cancel_bits(trr), .mb31_accept(m31), .tx_complete_irq(txi),
        .rx_complete_irq(rxi), .global_controller_irq(gi));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Ready is sampled mid-cycle so the decision is settled before the edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit da, dw, ta, tw;
        da = 0;
        dw = 0;
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(da && dw)) begin
            @(negedge core_clk);
            ta = !da && awready;
            tw = !dw && wready;
            @(posedge core_clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            da |= ta;
            dw |= tw;
        end
        do @(negedge core_clk); while (bvalid !== 1'b1);
        rs = bresp;
        @(posedge core_clk);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge core_clk); while (arready !== 1'b1);
        @(posedge core_clk);
        arvalid <= 1'b0;
        do @(negedge core_clk); while (rvalid !== 1'b1);
        rv = rdata;
        rs = rresp;
        @(posedge core_clk);
        rready <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        chk(rv, exp);
    endtask
    // Mailbox 31 filter: program mask and identifiers, result is registered
    task automatic flt(input logic [31:0] m, input logic [28:0] sid, input logic side,
            input logic [28:0] fid, input logic fide, input logic exp);
        wr(cmsf_pkg::OFF_ACCEPT_MASK, m);
        setup <= '{id: sid, ide: side};
        frame <= '{id: fid, ide: fide};
        repeat (3) @(posedge core_clk);
        chk({31'h0, m31}, {31'h0, exp});
    endtask
    task automatic tally_and_finish();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        #200000;
        n_fail++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        tally_and_finish();
    end
    initial begin
        repeat (16) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        for (int i = 2; i < 7; i++) rd_chk(8'(4 * i), 32'h00000000);
        wr(cmsf_pkg::OFF_MB_IRQ_MASK, 32'h80000008);
        wr(cmsf_pkg::OFF_TX_REQ, 32'h00000008);
        eng.send_ok(5'h03);
        eng.send_ok(5'h1F);
        rd_chk(cmsf_pkg::OFF_TX_DONE, 32'h00000008);
        rd_chk(cmsf_pkg::OFF_TX_REQ, 32'h00000000);
        chk({31'h0, txi}, 32'h00000001);
        wr(cmsf_pkg::OFF_TX_DONE, 32'h00000000);
        rd_chk(cmsf_pkg::OFF_TX_DONE, 32'h00000008);
        wr(cmsf_pkg::OFF_TX_REQ, 32'h00000008);
        rd_chk(cmsf_pkg::OFF_TX_DONE, 32'h00000000);
        wr(cmsf_pkg::OFF_GLB_IRQ_MASK, 32'h00000001);
        wr(cmsf_pkg::OFF_TX_CANCEL, 32'h00000008);
        repeat (2) @(posedge core_clk);
        rd_chk(cmsf_pkg::OFF_ABORT_DONE, 32'h00000008);
        chk(trs | trr, 32'h00000000);
        rd_chk(cmsf_pkg::OFF_GLB_IRQ_FLAGS, 32'h00000001);
        chk({31'h0, gi}, 32'h00000001);
        wr(cmsf_pkg::OFF_ABORT_DONE, 32'h00000000);
        rd_chk(cmsf_pkg::OFF_ABORT_DONE, 32'h00000008);
        wr(cmsf_pkg::OFF_ABORT_DONE, 32'h00000008);
        rd_chk(cmsf_pkg::OFF_ABORT_DONE, 32'h00000000);
        eng.set_busy(1'b1, 5'h05);
        wr(cmsf_pkg::OFF_TX_REQ, 32'h00000020);
        wr(cmsf_pkg::OFF_TX_CANCEL, 32'h00000020);
        rd_chk(cmsf_pkg::OFF_ABORT_DONE, 32'h00000000);
        chk(trs & trr, 32'h00000020);
        eng.abort_tx(5'h05);
        eng.set_busy(1'b0, 5'h00);
        rd_chk(cmsf_pkg::OFF_ABORT_DONE, 32'h00000020);
        chk(trs | trr, 32'h00000000);
        wr(cmsf_pkg::OFF_TX_REQ, 32'h00000020);
        rd_chk(cmsf_pkg::OFF_ABORT_DONE, 32'h00000000);
        wr(cmsf_pkg::OFF_TX_CANCEL, 32'h00000020);
        rd_chk(cmsf_pkg::OFF_ABORT_DONE, 32'h00000020);
        wr(cmsf_pkg::OFF_ABORT_DONE, 32'h00000020);
        wr(cmsf_pkg::OFF_GLB_IRQ_FLAGS, 32'h00000001);
        wr(cmsf_pkg::OFF_GLB_IRQ_MASK, 32'h00000002);
        eng.store_rx(5'h1F);
        rd_chk(cmsf_pkg::OFF_RX_PEND, 32'h80000000);
        chk({31'h0, rxi}, 32'h00000001);
        chk({31'h0, gi}, 32'h00000000);
        eng.store_rx(5'h1F);
        rd_chk(cmsf_pkg::OFF_RX_LOST, 32'h80000000);
        rd_chk(cmsf_pkg::OFF_RX_PEND, 32'h80000000);
        chk({31'h0, gi}, 32'h00000001);
        wr(cmsf_pkg::OFF_RX_LOST, 32'hFFFFFFFF);
        rd_chk(cmsf_pkg::OFF_RX_LOST, 32'h80000000);
        wr(cmsf_pkg::OFF_RX_PEND, 32'h00000000);
        rd_chk(cmsf_pkg::OFF_RX_PEND, 32'h80000000);
        wr(cmsf_pkg::OFF_RX_PEND, 32'h80000000);
        rd_chk(cmsf_pkg::OFF_RX_PEND, 32'h00000000);
        rd_chk(cmsf_pkg::OFF_RX_LOST, 32'h00000000);
        wr(8'h40, 32'h00000001);
        chk({30'h0, rs}, 32'h00000002);
        rd(8'h40);
        chk({30'h0, rs}, 32'h00000002);
        wstrb <= 4'h1;
        wr(cmsf_pkg::OFF_ACCEPT_MASK, 32'hFFFFFFFF);
        wstrb <= 4'hF;
        rd_chk(cmsf_pkg::OFF_ACCEPT_MASK, 32'h000000FF);
        flt(32'h00000000, 29'h1ABCDEF1, 1'b1, 29'h1ABCDEF1, 1'b1, 1'b1);
        flt(32'h00000000, 29'h1ABCDEF1, 1'b1, 29'h1ABCDEF0, 1'b1, 1'b0);
        flt(32'h00000001, 29'h1ABCDEF1, 1'b1, 29'h1ABCDEF0, 1'b1, 1'b1);
        flt(32'h00000000, 29'h1ABCDEF1, 1'b1, 29'h1ABCDEF1, 1'b0, 1'b0);
        flt(32'h80000000, 29'h1ABCDEF1, 1'b1, 29'h1ABCDEF1, 1'b0, 1'b1);
        flt(32'h00000000, 29'h1ABCDEF1, 1'b0, 29'h1ABCDEF0, 1'b0, 1'b1);
        flt(32'h00000000, 29'h1ABCDEF1, 1'b0, 29'h1AB8DEF1, 1'b0, 1'b0);
        rd_chk(cmsf_pkg::OFF_ACCEPT_MASK, 32'h00000000);
        rd_chk(cmsf_pkg::OFF_RX_PEND, 32'h00000000);
        tally_and_finish();
    end
endmodule

//--- hw/cmsf_pkg.sv
// Package: register map, field layout and carrier types of the mailbox status block
package cmsf_pkg;
    localparam int N_MB = 32;
    localparam int MB_W = 5;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int LAST_MB = 31;
    // Register byte offsets
    localparam logic [7:0] OFF_TX_REQ = 8'h00;
    localparam logic [7:0] OFF_TX_CANCEL = 8'h04;
    localparam logic [7:0] OFF_TX_DONE = 8'h08;
    localparam logic [7:0] OFF_ABORT_DONE = 8'h0C;
    localparam logic [7:0] OFF_RX_PEND = 8'h10;
    localparam logic [7:0] OFF_RX_LOST = 8'h14;
    localparam logic [7:0] OFF_ACCEPT_MASK = 8'h18;
    localparam logic [7:0] OFF_MB_IRQ_MASK = 8'h1C;
    localparam logic [7:0] OFF_MB_TX_IRQ = 8'h20;
    localparam logic [7:0] OFF_MB_RX_IRQ = 8'h24;
    localparam logic [7:0] OFF_GLB_IRQ_FLAGS = 8'h28;
    localparam logic [7:0] OFF_GLB_IRQ_MASK = 8'h2C;
    // Bit 31 is absent in every transmit-side bank
    localparam logic [31:0] TX_BANK_MASK = 32'h7FFFFFFF;
    localparam logic [31:0] ACCEPT_MASK_MASK = 32'h9FFFFFFF;
    localparam logic [31:0] GLB_IRQ_MASK_BITS = 32'h00000003;
    localparam logic [31:0] RESET_ZERO = 32'h00000000;
    localparam int FMT_MASK_BIT = 31;
    localparam int ID_MSB = 28;
    localparam int STD_ID_LSB = 18;
    localparam int GIRQ_TX_ABORT = 0;
    localparam int GIRQ_RX_LOST = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // One mailbox event from the protocol engine
    typedef struct packed {
        logic valid;
        logic [MB_W-1:0] mb;
    } cmsf_evt_t;

    // Identifier and format of a frame being filtered
    typedef struct packed {
        logic [ID_MSB:0] id;
        logic ide;
    } cmsf_frame_t;
endpackage

//--- hw/cmsf_top.sv
// Mailbox status flag banks, local acceptance filter and AXI4-Lite register slave
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
module cmsf_top #(
    parameter int N_MB = cmsf_pkg::N_MB
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [cmsf_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [cmsf_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [cmsf_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [cmsf_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire cmsf_pkg::cmsf_evt_t tx_ok_evt,
    input wire cmsf_pkg::cmsf_evt_t tx_abort_evt,
    input wire cmsf_pkg::cmsf_evt_t tx_active,
    input wire cmsf_pkg::cmsf_evt_t rx_store_evt,
    input wire cmsf_pkg::cmsf_frame_t rx_frame,
    input wire cmsf_pkg::cmsf_frame_t mb31_setup,
    output logic [N_MB-1:0] transmit_request_bits,
    output logic [N_MB-1:0] transmit_cancel_bits,
    output logic mb31_accept,
    output logic tx_complete_irq,
    output logic rx_complete_irq,
    output logic global_controller_irq
);
    logic [N_MB-1:0] trs_r, trr_r, ta_r, aa_r, rmp_r, rml_r;
    logic [N_MB-1:0] mbim_r, mbtif_r, mbrif_r, lam_r;
    logic [1:0] gif_r, gim_r;
    logic aw_full_r, w_full_r, bvalid_r, rvalid_r, accept_r;
    logic [1:0] bresp_r, rresp_r;
    logic [cmsf_pkg::ADDR_W-1:0] awaddr_r;
    logic [cmsf_pkg::DATA_W-1:0] wdata_r, rdata_r, rd_nxt;
    logic [3:0] wstrb_r;
    logic rd_hit, wr_en, wr_hit;
    logic [N_MB-1:0] wmask;
    logic [N_MB-1:0] ok_vec, abort_evt_vec, busy_vec, store_vec;
    logic [N_MB-1:0] cancel_now, abort_set, ta_set, rmp_set, rml_set;
    logic [N_MB-1:0] wr_trs, wr_trr, wr_ta, wr_aa, wr_rmp, wr_mbtif, wr_mbrif;
    logic [1:0] wr_gif;

    function automatic logic [N_MB-1:0] decode(input cmsf_pkg::cmsf_evt_t e);
        logic [N_MB-1:0] v;
        v = '0;
        if (e.valid) begin
            v[e.mb] = 1'b1;
        end
        return v;
    endfunction

    function automatic logic [31:0] wmask_full(input logic [3:0] s);
        return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    // AXI4-Lite write path: address and data taken in either order, then one response
    assign s_axi_awready = !aw_full_r && !bvalid_r;
    assign s_axi_wready = !w_full_r && !bvalid_r;
    assign wr_en = aw_full_r && w_full_r && !bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            aw_full_r <= 1'b0;
            awaddr_r <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
        end else if (wr_en) begin
            aw_full_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            w_full_r <= 1'b0;
            wdata_r <= '0;
            wstrb_r <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
        end else if (wr_en) begin
            w_full_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            bvalid_r <= 1'b0;
            bresp_r <= cmsf_pkg::RESP_OKAY;
        end else if (wr_en) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_hit ? cmsf_pkg::RESP_OKAY : cmsf_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // Lanes without a strobe write as zero, which is harmless for every W1C and W1S bank
    always_comb begin
        wmask = wr_en ? (wdata_r & wmask_full(wstrb_r)) : '0;
        wr_trs = '0;
        wr_trr = '0;
        wr_ta = '0;
        wr_aa = '0;
        wr_rmp = '0;
        wr_mbtif = '0;
        wr_mbrif = '0;
        wr_gif = '0;
        wr_hit = 1'b1;
        if (awaddr_r == cmsf_pkg::OFF_TX_REQ) begin
            wr_trs = wmask & cmsf_pkg::TX_BANK_MASK;
        end else if (awaddr_r == cmsf_pkg::OFF_TX_CANCEL) begin
            wr_trr = wmask & cmsf_pkg::TX_BANK_MASK;
        end else if (awaddr_r == cmsf_pkg::OFF_TX_DONE) begin
            wr_ta = wmask & cmsf_pkg::TX_BANK_MASK;
        end else if (awaddr_r == cmsf_pkg::OFF_ABORT_DONE) begin
            wr_aa = wmask & cmsf_pkg::TX_BANK_MASK;
        end else if (awaddr_r == cmsf_pkg::OFF_RX_PEND) begin
            wr_rmp = wmask;
        end else if (awaddr_r == cmsf_pkg::OFF_MB_TX_IRQ) begin
            wr_mbtif = wmask;
        end else if (awaddr_r == cmsf_pkg::OFF_MB_RX_IRQ) begin
            wr_mbrif = wmask;
        end else if (awaddr_r == cmsf_pkg::OFF_GLB_IRQ_FLAGS) begin
            wr_gif = wmask[1:0];
        end else if (awaddr_r == cmsf_pkg::OFF_RX_LOST || awaddr_r == cmsf_pkg::OFF_ACCEPT_MASK
                     || awaddr_r == cmsf_pkg::OFF_MB_IRQ_MASK
                     || awaddr_r == cmsf_pkg::OFF_GLB_IRQ_MASK) begin
            wr_hit = 1'b1;
        end else begin
            wr_hit = 1'b0;
        end
    end

    // Engine events decoded to one-hot mailbox vectors
    always_comb begin
        ok_vec = decode(tx_ok_evt) & cmsf_pkg::TX_BANK_MASK;
        abort_evt_vec = decode(tx_abort_evt) & cmsf_pkg::TX_BANK_MASK;
        busy_vec = decode(tx_active);
        store_vec = decode(rx_store_evt);
        cancel_now = trr_r & trs_r & ~busy_vec & ~ok_vec;
        abort_set = abort_evt_vec | cancel_now;
        ta_set = ok_vec;
        rmp_set = store_vec;
        rml_set = store_vec & rmp_r;
    end

    // Request clears on completion or abort; a cancel already in flight waits for the engine
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            trs_r <= cmsf_pkg::RESET_ZERO;
        end else begin
            trs_r <= (trs_r | wr_trs) & ~(ok_vec | abort_set) & cmsf_pkg::TX_BANK_MASK;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            trr_r <= cmsf_pkg::RESET_ZERO;
        end else begin
            trr_r <= (trr_r | wr_trr) & ~(ok_vec | abort_set) & cmsf_pkg::TX_BANK_MASK;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ta_r <= cmsf_pkg::RESET_ZERO;
        end else begin
            ta_r <= ((ta_r & ~(wr_ta | wr_trs)) | ta_set) & cmsf_pkg::TX_BANK_MASK;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            aa_r <= cmsf_pkg::RESET_ZERO;
        end else begin
            aa_r <= ((aa_r & ~(wr_aa | wr_trs)) | abort_set) & cmsf_pkg::TX_BANK_MASK;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rmp_r <= cmsf_pkg::RESET_ZERO;
        end else begin
            rmp_r <= (rmp_r & ~wr_rmp) | rmp_set;
        end
    end

    // Lost flags have no write path of their own
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rml_r <= cmsf_pkg::RESET_ZERO;
        end else begin
            rml_r <= (rml_r & ~wr_rmp) | rml_set;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            mbtif_r <= cmsf_pkg::RESET_ZERO;
        end else begin
            mbtif_r <= (mbtif_r & ~wr_mbtif) | (ta_set & mbim_r);
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            mbrif_r <= cmsf_pkg::RESET_ZERO;
        end else begin
            mbrif_r <= (mbrif_r & ~wr_mbrif) | (rmp_set & mbim_r);
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            gif_r <= '0;
        end else begin
            gif_r[cmsf_pkg::GIRQ_TX_ABORT] <= (gif_r[cmsf_pkg::GIRQ_TX_ABORT]
                & ~wr_gif[cmsf_pkg::GIRQ_TX_ABORT]) | (|abort_set);
            gif_r[cmsf_pkg::GIRQ_RX_LOST] <= (gif_r[cmsf_pkg::GIRQ_RX_LOST]
                & ~wr_gif[cmsf_pkg::GIRQ_RX_LOST]) | (|rml_set);
        end
    end

    // Plain read/write configuration registers
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            mbim_r <= cmsf_pkg::RESET_ZERO;
            lam_r <= cmsf_pkg::RESET_ZERO;
            gim_r <= '0;
        end else if (wr_en) begin
            if (awaddr_r == cmsf_pkg::OFF_MB_IRQ_MASK) begin
                mbim_r <= (mbim_r & ~wmask_full(wstrb_r)) | wmask;
            end else if (awaddr_r == cmsf_pkg::OFF_ACCEPT_MASK) begin
                lam_r <= ((lam_r & ~wmask_full(wstrb_r)) | wmask) & cmsf_pkg::ACCEPT_MASK_MASK;
            end else if (awaddr_r == cmsf_pkg::OFF_GLB_IRQ_MASK && wstrb_r[0]) begin
                gim_r <= wmask[1:0];
            end
        end
    end

    assign transmit_request_bits = trs_r;
    assign transmit_cancel_bits = trr_r;
    assign tx_complete_irq = |mbtif_r;
    assign rx_complete_irq = |mbrif_r;
    assign global_controller_irq = |(gif_r & gim_r);

    // Local mask filter for the last mailbox; the mask is sampled live, so it must be static
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            accept_r <= 1'b0;
        end else begin
            accept_r <= (lam_r[cmsf_pkg::FMT_MASK_BIT] || rx_frame.ide == mb31_setup.ide)
                && (rx_frame.ide
                    ? (((rx_frame.id ^ mb31_setup.id) & ~lam_r[cmsf_pkg::ID_MSB:0]) == '0)
                    : (((rx_frame.id[cmsf_pkg::ID_MSB:cmsf_pkg::STD_ID_LSB]
                        ^ mb31_setup.id[cmsf_pkg::ID_MSB:cmsf_pkg::STD_ID_LSB])
                        & ~lam_r[cmsf_pkg::ID_MSB:cmsf_pkg::STD_ID_LSB]) == '0));
        end
    end
    assign mb31_accept = accept_r;

    // AXI4-Lite read path: one cycle from address to data
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    always_comb begin
        rd_nxt = '0;
        rd_hit = 1'b1;
        if (s_axi_araddr == cmsf_pkg::OFF_TX_REQ) begin
            rd_nxt = trs_r;
        end else if (s_axi_araddr == cmsf_pkg::OFF_TX_CANCEL) begin
            rd_nxt = trr_r;
        end else if (s_axi_araddr == cmsf_pkg::OFF_TX_DONE) begin
            rd_nxt = ta_r;
        end else if (s_axi_araddr == cmsf_pkg::OFF_ABORT_DONE) begin
            rd_nxt = aa_r;
        end else if (s_axi_araddr == cmsf_pkg::OFF_RX_PEND) begin
            rd_nxt = rmp_r;
        end else if (s_axi_araddr == cmsf_pkg::OFF_RX_LOST) begin
            rd_nxt = rml_r;
        end else if (s_axi_araddr == cmsf_pkg::OFF_ACCEPT_MASK) begin
            rd_nxt = lam_r;
        end else if (s_axi_araddr == cmsf_pkg::OFF_MB_IRQ_MASK) begin
            rd_nxt = mbim_r;
        end else if (s_axi_araddr == cmsf_pkg::OFF_MB_TX_IRQ) begin
            rd_nxt = mbtif_r;
        end else if (s_axi_araddr == cmsf_pkg::OFF_MB_RX_IRQ) begin
            rd_nxt = mbrif_r;
        end else if (s_axi_araddr == cmsf_pkg::OFF_GLB_IRQ_FLAGS) begin
            rd_nxt = {30'h00000000, gif_r};
        end else if (s_axi_araddr == cmsf_pkg::OFF_GLB_IRQ_MASK) begin
            rd_nxt = {30'h00000000, gim_r};
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= cmsf_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_nxt;
            rresp_r <= rd_hit ? cmsf_pkg::RESP_OKAY : cmsf_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // Checks
    sequence tx_ok_seq;
        tx_ok_evt.valid && tx_ok_evt.mb != cmsf_pkg::MB_W'(cmsf_pkg::LAST_MB);
    endsequence
    sequence idle_cancel_seq;
        trr_r != '0 && (trr_r & trs_r & ~busy_vec & ~ok_vec) != '0;
    endsequence

    ta_set_a: assert property (@(posedge core_clk) disable iff (!rstn)
        tx_ok_seq |=> ta_r[$past(tx_ok_evt.mb)])
        else $error("transmit-done flag not set after send");
    ta_clear_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (wr_ta | wr_trs) != '0 |=> (ta_r & $past(wr_ta | wr_trs) & ~$past(ta_set)) == '0)
        else $error("transmit-done flag survived a clearing write");
    tx_irq_a: assert property (@(posedge core_clk) disable iff (!rstn)
        tx_ok_seq ##0 mbim_r[tx_ok_evt.mb] |=> tx_complete_irq)
        else $error("transmit interrupt missing");
    top_bit_zero_a: assert property (@(posedge core_clk) disable iff (!rstn)
        !ta_r[cmsf_pkg::LAST_MB] && !aa_r[cmsf_pkg::LAST_MB] && !trs_r[cmsf_pkg::LAST_MB])
        else $error("bit 31 of a transmit bank is set");
    idle_cancel_a: assert property (@(posedge core_clk) disable iff (!rstn)
        idle_cancel_seq |=> ((aa_r & $past(cancel_now)) == $past(cancel_now))
            && ((trs_r | trr_r) & $past(cancel_now)) == '0)
        else $error("idle cancel did not abort");
    abort_gb_a: assert property (@(posedge core_clk) disable iff (!rstn)
        abort_set != '0 && gim_r[cmsf_pkg::GIRQ_TX_ABORT] |=> global_controller_irq)
        else $error("abort did not raise global interrupt");
    rx_lost_a: assert property (@(posedge core_clk) disable iff (!rstn)
        rx_store_evt.valid && rmp_r[rx_store_evt.mb]
        |=> rml_r[$past(rx_store_evt.mb)] && rmp_r[$past(rx_store_evt.mb)])
        else $error("overwrite did not flag lost message");
    rx_pend_a: assert property (@(posedge core_clk) disable iff (!rstn)
        rx_store_evt.valid |=> rmp_r[$past(rx_store_evt.mb)])
        else $error("pending flag not set after store");
    lost_clear_a: assert property (@(posedge core_clk) disable iff (!rstn)
        $rose(rml_r != '0) || $fell(rml_r != '0) |-> $past(rml_set != '0 || wr_rmp != '0))
        else $error("lost flag changed without cause");
    std_filter_a: assert property (@(posedge core_clk) disable iff (!rstn)
        !rx_frame.ide && !mb31_setup.ide && lam_r[cmsf_pkg::ID_MSB:cmsf_pkg::STD_ID_LSB] == '0
        && rx_frame.id[cmsf_pkg::ID_MSB:cmsf_pkg::STD_ID_LSB]
            == mb31_setup.id[cmsf_pkg::ID_MSB:cmsf_pkg::STD_ID_LSB]
        |=> mb31_accept)
        else $error("standard frame rejected on matching high bits");
endmodule
